// ===== verilog/timer16_pkg.sv
// Constants, register offsets and mode codes for the 16-bit timer counter unit.
package timer16_pkg;

	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 8;
	localparam int          CNT_W         = 16;

	// Byte locations on the 8-bit CPU data bus.
	localparam logic [3:0]  ADDR_CNT_LO   = 4'h0;
	localparam logic [3:0]  ADDR_CNT_HI   = 4'h1;
	localparam logic [3:0]  ADDR_CMPA_LO  = 4'h2;
	localparam logic [3:0]  ADDR_CMPA_HI  = 4'h3;
	localparam logic [3:0]  ADDR_CMPB_LO  = 4'h4;
	localparam logic [3:0]  ADDR_CMPB_HI  = 4'h5;
	localparam logic [3:0]  ADDR_CAP_LO   = 4'h6;
	localparam logic [3:0]  ADDR_CAP_HI   = 4'h7;
	localparam logic [3:0]  ADDR_CTRL_A   = 4'h8;
	localparam logic [3:0]  ADDR_CTRL_B   = 4'h9;
	localparam logic [3:0]  ADDR_FLAGS    = 4'ha;

	// Field positions.
	localparam int          CTRLA_WGM_LSB = 0;
	localparam int          CTRLB_CS_LSB  = 0;
	localparam int          CTRLB_WGM_LSB = 3;
	localparam int          FLAG_OVF_BIT  = 0;
	localparam int          FLAG_DIR_BIT  = 1;

	// Reset values.
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [15:0] WORD_RESET    = 16'h0000;

	// Count limits.
	localparam logic [15:0] CNT_BOTTOM    = 16'h0000;
	localparam logic [15:0] CNT_MAX       = 16'hffff;
	localparam logic [15:0] TOP_FIX8      = 16'h00ff;
	localparam logic [15:0] TOP_FIX9      = 16'h01ff;
	localparam logic [15:0] TOP_FIX10     = 16'h03ff;
	localparam logic [15:0] CNT_STEP      = 16'h0001;

	// Clock select codes.
	localparam logic [2:0]  CS_STOP       = 3'h0;
	localparam logic [2:0]  CS_DIV1       = 3'h1;
	localparam logic [2:0]  CS_DIV8       = 3'h2;
	localparam logic [2:0]  CS_DIV64      = 3'h3;
	localparam logic [2:0]  CS_DIV256     = 3'h4;
	localparam logic [2:0]  CS_DIV1024    = 3'h5;
	localparam logic [2:0]  CS_EXT_FALL   = 3'h6;
	localparam logic [2:0]  CS_EXT_RISE   = 3'h7;

	// Prescaler: division factors 8, 64, 256, 1024 as bit counts of a free counter.
	localparam int          PRESC_W       = 10;
	localparam int          PRESC_TAPS    = 4;
	localparam int          PRESC_TAP_BITS [PRESC_TAPS] = '{3, 6, 8, 10};

	// Waveform mode codes.
	localparam logic [3:0]  WGM_NORMAL    = 4'h0;
	localparam logic [3:0]  WGM_PC8       = 4'h1;
	localparam logic [3:0]  WGM_PC9       = 4'h2;
	localparam logic [3:0]  WGM_PC10      = 4'h3;
	localparam logic [3:0]  WGM_CTC_A     = 4'h4;
	localparam logic [3:0]  WGM_FAST8     = 4'h5;
	localparam logic [3:0]  WGM_FAST9     = 4'h6;
	localparam logic [3:0]  WGM_FAST10    = 4'h7;
	localparam logic [3:0]  WGM_PFC_CAP   = 4'h8;
	localparam logic [3:0]  WGM_PFC_A     = 4'h9;
	localparam logic [3:0]  WGM_PC_CAP    = 4'ha;
	localparam logic [3:0]  WGM_PC_A      = 4'hb;
	localparam logic [3:0]  WGM_CTC_CAP   = 4'hc;
	localparam logic [3:0]  WGM_RESERVED  = 4'hd;
	localparam logic [3:0]  WGM_FAST_CAP  = 4'he;
	localparam logic [3:0]  WGM_FAST_A    = 4'hf;

endpackage

// ===== verilog/prescale_divider.sv
// Free-running prescaler that issues one-cycle enable pulses at fixed division factors.
`timescale 1ns/1ps
module prescale_divider (
	input  wire logic                             core_clk,
	input  wire logic                             reset,
	output logic [timer16_pkg::PRESC_TAPS-1:0]    div_pulse
);
	import timer16_pkg::*;

	logic [PRESC_W-1:0] presc_reg;

	// The counter never stops, so the first tick after a start may come early.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	logic [PRESC_TAPS-1:0] tap_done;

	genvar i;
	generate
		for (i = 0; i < PRESC_TAPS; i++) begin : g_tap
			assign tap_done[i] = &presc_reg[PRESC_TAP_BITS[i]-1:0];
		end
	endgenerate

	// One register for all taps keeps the output vector with a single driver.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_pulse <= '0;
		end else begin
			div_pulse <= tap_done;
		end
	end

endmodule

// ===== verilog/timer16_counter_unit.sv
// Counter core of a 16-bit timer with byte-wide CPU access through a shared high-byte holder.
`timescale 1ns/1ps
module timer16_counter_unit (
	input  wire logic                              core_clk,
	input  wire logic                              reset,
	input  wire logic [timer16_pkg::ADDR_W-1:0]    io_addr,
	input  wire logic                              io_wr,
	input  wire logic                              io_rd,
	input  wire logic [timer16_pkg::DATA_W-1:0]    io_wdata,
	input  wire logic                              external_count_pin,
	input  wire logic                              capture_strobe,
	output logic      [timer16_pkg::DATA_W-1:0]    io_rdata,
	output logic      [timer16_pkg::CNT_W-1:0]     count_value,
	output logic                                   timer_clock_enable,
	output logic                                   top_flag,
	output logic                                   bottom_flag,
	output logic                                   max_flag,
	output logic                                   overflow_flag,
	output logic                                   count_down,
	output logic      [3:0]                        waveform_mode_field
);
	import timer16_pkg::*;

	logic [15:0]           count_reg;
	logic [15:0]           count_next;
	logic [7:0]            temp_reg;
	logic [15:0]           compare_reg_a;
	logic [15:0]           compare_reg_b;
	logic [15:0]           capture_reg;
	logic [7:0]            control_reg_a;
	logic [7:0]            control_reg_b;
	logic                  dir_down_reg;
	logic                  ovf_reg;
	logic [7:0]            rdata_reg;
	logic                  ext_meta_reg;
	logic                  ext_sync_reg;
	logic                  ext_prev_reg;
	logic                  tick_reg;
	logic                  top_reg;
	logic                  bottom_reg;
	logic                  max_reg;
	logic [PRESC_TAPS-1:0] div_pulse;

	prescale_divider u_prescale (
		.core_clk  (core_clk),
		.reset     (reset),
		.div_pulse (div_pulse)
	);

	// Address decode.
	wire wr_cnt_lo  = io_wr && (io_addr == ADDR_CNT_LO);
	wire wr_cmpa_lo = io_wr && (io_addr == ADDR_CMPA_LO);
	wire wr_cmpb_lo = io_wr && (io_addr == ADDR_CMPB_LO);
	wire wr_cap_lo  = io_wr && (io_addr == ADDR_CAP_LO);
	wire wr_ctrl_a  = io_wr && (io_addr == ADDR_CTRL_A);
	wire wr_ctrl_b  = io_wr && (io_addr == ADDR_CTRL_B);
	wire wr_flags   = io_wr && (io_addr == ADDR_FLAGS);
	wire wr_any_hi  = io_wr && ((io_addr == ADDR_CNT_HI) || (io_addr == ADDR_CMPA_HI) ||
	                  (io_addr == ADDR_CMPB_HI) || (io_addr == ADDR_CAP_HI));
	wire rd_cnt_lo  = io_rd && (io_addr == ADDR_CNT_LO);
	wire rd_cap_lo  = io_rd && (io_addr == ADDR_CAP_LO);

	// Mode field is split between the two control registers.
	wire [3:0] mode = {control_reg_b[CTRLB_WGM_LSB+1:CTRLB_WGM_LSB],
	                   control_reg_a[CTRLA_WGM_LSB+1:CTRLA_WGM_LSB]};
	wire [2:0] clock_select_field = control_reg_b[CTRLB_CS_LSB+2:CTRLB_CS_LSB];

	// TOP selection per mode.
	wire top_fix8  = (mode == WGM_PC8) || (mode == WGM_FAST8);
	wire top_fix9  = (mode == WGM_PC9) || (mode == WGM_FAST9);
	wire top_fix10 = (mode == WGM_PC10) || (mode == WGM_FAST10);
	wire top_cmpa  = (mode == WGM_CTC_A) || (mode == WGM_PFC_A) ||
	                 (mode == WGM_PC_A) || (mode == WGM_FAST_A);
	wire top_cap   = (mode == WGM_PFC_CAP) || (mode == WGM_PC_CAP) ||
	                 (mode == WGM_CTC_CAP) || (mode == WGM_FAST_CAP);
	wire [15:0] top_value = top_fix8  ? TOP_FIX8 :
	                        top_fix9  ? TOP_FIX9 :
	                        top_fix10 ? TOP_FIX10 :
	                        top_cmpa  ? compare_reg_a :
	                        top_cap   ? capture_reg : CNT_MAX;

	wire is_dual    = top_fix8 || top_fix9 || top_fix10 ? (mode <= WGM_PC10) :
	                  (mode >= WGM_PFC_CAP) && (mode <= WGM_PC_A);
	wire is_clear   = (mode == WGM_CTC_A) || (mode == WGM_FAST8) || (mode == WGM_FAST9) ||
	                  (mode == WGM_FAST10) || (mode == WGM_CTC_CAP) ||
	                  (mode == WGM_FAST_CAP) || (mode == WGM_FAST_A);
	wire ovf_at_top = is_clear && (mode != WGM_CTC_A) && (mode != WGM_CTC_CAP);

	// External pin passes two flip-flops before the edge detector looks at it.
	wire ext_rise = ext_sync_reg && !ext_prev_reg;
	wire ext_fall = !ext_sync_reg && ext_prev_reg;

	// Timer clock selection; code zero gives no tick at all.
	wire tick = (clock_select_field == CS_DIV1) ||
	            ((clock_select_field == CS_DIV8) && div_pulse[0]) ||
	            ((clock_select_field == CS_DIV64) && div_pulse[1]) ||
	            ((clock_select_field == CS_DIV256) && div_pulse[2]) ||
	            ((clock_select_field == CS_DIV1024) && div_pulse[3]) ||
	            ((clock_select_field == CS_EXT_FALL) && ext_fall) ||
	            ((clock_select_field == CS_EXT_RISE) && ext_rise);

	wire at_top    = (count_reg == top_value);
	wire at_bottom = (count_reg == CNT_BOTTOM);
	wire at_max    = (count_reg == CNT_MAX);
	wire step_down = is_dual && (at_top || (dir_down_reg && !at_bottom));
	wire do_clear  = is_clear && at_top;
	wire count_tick = tick && !wr_cnt_lo;

	// A CPU write of the count low byte always wins; the timer tick only acts when no such write is present.
	assign count_next = wr_cnt_lo   ? {temp_reg, io_wdata} :
	                    !count_tick ? count_reg :
	                    do_clear    ? CNT_BOTTOM :
	                    step_down   ? count_reg - CNT_STEP :
	                                  count_reg + CNT_STEP;

	wire ovf_event = count_tick && (is_dual ? at_bottom :
	                 ovf_at_top ? at_top : at_max);
	wire ovf_clear = wr_flags && io_wdata[FLAG_OVF_BIT];
	wire dir_next  = !is_dual ? 1'b0 : count_tick ? step_down : dir_down_reg;

	// The holder sees every high-byte write and count or capture low reads.
	wire [7:0] temp_next = wr_any_hi ? io_wdata :
	                       rd_cnt_lo ? count_reg[15:8] :
	                       rd_cap_lo ? capture_reg[15:8] : temp_reg;

	// Capture writes only take effect when the capture register sets TOP.
	wire cap_wr_ok = wr_cap_lo && top_cap;

	wire [7:0] flags_byte = {6'h00, dir_down_reg, ovf_reg};
	wire [7:0] read_mux =
		(io_addr == ADDR_CNT_LO)  ? count_reg[7:0] :
		(io_addr == ADDR_CNT_HI)  ? temp_reg :
		(io_addr == ADDR_CMPA_LO) ? compare_reg_a[7:0] :
		(io_addr == ADDR_CMPA_HI) ? compare_reg_a[15:8] :
		(io_addr == ADDR_CMPB_LO) ? compare_reg_b[7:0] :
		(io_addr == ADDR_CMPB_HI) ? compare_reg_b[15:8] :
		(io_addr == ADDR_CAP_LO)  ? capture_reg[7:0] :
		(io_addr == ADDR_CAP_HI)  ? temp_reg :
		(io_addr == ADDR_CTRL_A)  ? control_reg_a :
		(io_addr == ADDR_CTRL_B)  ? control_reg_b :
		(io_addr == ADDR_FLAGS)   ? flags_byte : BYTE_RESET;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else begin
			ext_meta_reg <= external_count_pin;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_reg    <= WORD_RESET;
			temp_reg     <= BYTE_RESET;
			dir_down_reg <= 1'b0;
			ovf_reg      <= 1'b0;
		end else begin
			count_reg    <= count_next;
			temp_reg     <= temp_next;
			dir_down_reg <= dir_next;
			ovf_reg      <= ovf_event || (ovf_reg && !ovf_clear);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			compare_reg_a <= WORD_RESET;
			compare_reg_b <= WORD_RESET;
			capture_reg   <= WORD_RESET;
			control_reg_a <= BYTE_RESET;
			control_reg_b <= BYTE_RESET;
		end else begin
			if (wr_cmpa_lo) begin
				compare_reg_a <= {temp_reg, io_wdata};
			end
			if (wr_cmpb_lo) begin
				compare_reg_b <= {temp_reg, io_wdata};
			end
			if (cap_wr_ok) begin
				capture_reg <= {temp_reg, io_wdata};
			end else if (capture_strobe && !top_cap) begin
				capture_reg <= count_reg;
			end
			if (wr_ctrl_a) begin
				control_reg_a <= io_wdata;
			end
			if (wr_ctrl_b) begin
				control_reg_b <= io_wdata;
			end
		end
	end

	// Limit flags follow the value the count takes at this edge.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_reg  <= BYTE_RESET;
			tick_reg   <= 1'b0;
			top_reg    <= 1'b0;
			bottom_reg <= 1'b1;
			max_reg    <= 1'b0;
		end else begin
			if (io_rd) begin
				rdata_reg <= read_mux;
			end
			tick_reg   <= tick;
			top_reg    <= (count_next == top_value);
			bottom_reg <= (count_next == CNT_BOTTOM);
			max_reg    <= (count_next == CNT_MAX);
		end
	end

	assign io_rdata            = rdata_reg;
	assign count_value         = count_reg;
	assign timer_clock_enable  = tick_reg;
	assign top_flag            = top_reg;
	assign bottom_flag         = bottom_reg;
	assign max_flag            = max_reg;
	assign overflow_flag       = ovf_reg;
	assign count_down          = dir_down_reg;
	assign waveform_mode_field = {control_reg_b[CTRLB_WGM_LSB+1:CTRLB_WGM_LSB],
	                              control_reg_a[CTRLA_WGM_LSB+1:CTRLA_WGM_LSB]};

	// Checks on the behaviour above.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	AST_BOTTOM: assert property ((count_value == CNT_BOTTOM) == bottom_flag)
		else $error("Bottom flag disagrees with count.");
	AST_MAX: assert property ((count_value == CNT_MAX) == max_flag)
		else $error("Max flag disagrees with count.");
	AST_TOP_FIX8: assert property ((mode == WGM_FAST8) && tick && !io_wr &&
		(count_reg == TOP_FIX8) |=> (count_value == CNT_BOTTOM) && overflow_flag)
		else $error("Fixed 8-bit top did not wrap.");
	AST_LOW_WRITE: assert property (wr_cnt_lo |=>
		count_value == {$past(temp_reg), $past(io_wdata)})
		else $error("Low byte write did not load full count.");
	AST_LOW_READ: assert property (rd_cnt_lo && !io_wr |=>
		temp_reg == $past(count_reg[15:8]))
		else $error("Low byte read did not latch high byte.");
	AST_CMP_HIGH: assert property (io_rd && !io_wr && (io_addr == ADDR_CMPA_HI) |=>
		(io_rdata == $past(compare_reg_a[15:8])) && $stable(temp_reg))
		else $error("Compare high read used the holder.");
	AST_HOLD: assert property (!wr_any_hi && !rd_cnt_lo && !rd_cap_lo |=> $stable(temp_reg))
		else $error("Holder changed without cause.");
	AST_STOP: assert property ((clock_select_field == CS_STOP) && !wr_cnt_lo |=>
		$stable(count_value))
		else $error("Counter moved with no clock source.");
	AST_WRITE_WINS: assert property (wr_cnt_lo && tick |=>
		count_value == {$past(temp_reg), $past(io_wdata)})
		else $error("Count beat a CPU write.");
	AST_STEP_UP: assert property ((mode == WGM_NORMAL) && count_tick && !at_max |=>
		count_value == $past(count_reg) + CNT_STEP)
		else $error("Normal mode did not step by one.");
	AST_OVF_SET: assert property ((mode == WGM_NORMAL) && count_tick && at_max |=>
		overflow_flag ##1 overflow_flag || $past(ovf_clear))
		else $error("Overflow flag not set on wrap.");
	AST_EXT_RISE: assert property ((clock_select_field == CS_EXT_RISE) && ext_rise |=>
		timer_clock_enable)
		else $error("External rising edge gave no tick.");
	AST_STEP_DOWN: assert property (is_dual && count_tick && at_top && !at_bottom |=>
		count_value == $past(count_reg) - CNT_STEP)
		else $error("Dual slope did not turn down at top.");
	AST_CLEAR: assert property (is_clear && count_tick && at_top |=>
		count_value == CNT_BOTTOM)
		else $error("Clear at top left bits set.");
	AST_HOLDER_LOAD: assert property (wr_any_hi |=> temp_reg == $past(io_wdata))
		else $error("High byte write missed the holder.");

	COV_WRAP: cover property ((mode == WGM_NORMAL) && count_tick && at_max);
	COV_DUAL_TURN: cover property (is_dual && count_tick && at_top ##1 count_down);
	COV_WRITE_TICK: cover property (wr_cnt_lo && tick);
	COV_EXT_FALL: cover property ((clock_select_field == CS_EXT_FALL) && ext_fall);

endmodule

// ===== tb/cpu_bus_model.sv
// Behavioural 8-bit CPU that drives the timer's byte-wide access port.
`timescale 1ns/1ps
module cpu_bus_model (
	input  wire logic       core_clk,
	output logic [3:0]      io_addr,
	output logic            io_wr,
	output logic            io_rd,
	output logic [7:0]      io_wdata,
	input  wire logic [7:0] io_rdata
);
	initial begin
		io_addr = 4'h0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end

	// Released lines show the inverse so stale values are never mistaken for live ones.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge core_clk);
		io_wr <= 1'b0;
		io_addr <= ~a;
		io_wdata <= ~d;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge core_clk);
		io_rd <= 1'b0;
		io_addr <= ~a;
		@(negedge core_clk);
		d = io_rdata;
	endtask

	// Accesses run one at a time, so no other code can disturb the shared holder.
	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		wr(lo + 4'h1, v[15:8]);
		wr(lo, v[7:0]);
	endtask

	task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
		rd(lo, v[7:0]);
		rd(lo + 4'h1, v[15:8]);
	endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the 16-bit timer counter unit.
`timescale 1ns/1ps
module tb_top;
	import timer16_pkg::*;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic        external_count_pin = 1'b0;
	logic        capture_strobe = 1'b0;
	logic [15:0] count_value;
	logic        timer_clock_enable;
	logic        top_flag;
	logic        bottom_flag;
	logic        max_flag;
	logic        overflow_flag;
	logic        count_down;
	logic [3:0]  waveform_mode_field;
	int          n_errors = 0;
	int          n_tests = 0;
	int          k;
	logic [15:0] v;
	logic [7:0]  b;
	logic [3:0]  m;
	logic        dual;
	logic [3:0]  mode_tab [10] = '{WGM_PC8, WGM_PC9, WGM_PC10, WGM_CTC_A,
		WGM_FAST8, WGM_FAST9, WGM_FAST10, WGM_FAST_A, WGM_PC_A, WGM_CTC_CAP};
	logic [15:0] top_tab [10] = '{TOP_FIX8, TOP_FIX9, TOP_FIX10, 16'h0040,
		TOP_FIX8, TOP_FIX9, TOP_FIX10, 16'h0040, 16'h0040, 16'h1234};
	int          div_tab [4] = '{8, 64, 256, 1024};

	always #20 core_clk = ~core_clk;

	timer16_counter_unit dut (
		.core_clk(core_clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .external_count_pin(external_count_pin),
		.capture_strobe(capture_strobe), .io_rdata(io_rdata), .count_value(count_value),
		.timer_clock_enable(timer_clock_enable), .top_flag(top_flag),
		.bottom_flag(bottom_flag), .max_flag(max_flag), .overflow_flag(overflow_flag),
		.count_down(count_down), .waveform_mode_field(waveform_mode_field)
	);

	cpu_bus_model cpu (
		.core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Counts cycles up to the next timer tick; bounded so a dead prescaler cannot hang.
	task automatic tick_gap(output int n);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (timer_clock_enable !== 1'b1 && n < 1100);
	endtask

	task automatic results();
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#2400000;
		n_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		results();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		chk(16'(bottom_flag), 16'h0001);
		cpu.rd16(ADDR_CNT_LO, v);
		chk(v, WORD_RESET);
		cpu.wr16(ADDR_CNT_LO, 16'h01ff);
		@(negedge core_clk);
		chk(count_value, 16'h01ff);
		repeat (20) @(negedge core_clk);
		chk(count_value, 16'h01ff);
		cpu.rd16(ADDR_CNT_LO, v);
		chk(v, 16'h01ff);
		cpu.wr(ADDR_CMPA_HI, 8'hab);
		cpu.wr(ADDR_CMPA_LO, 8'h00);
		cpu.wr(ADDR_CMPB_LO, 8'h11);
		cpu.rd16(ADDR_CMPB_LO, v);
		chk(v, 16'hab11);
		cpu.wr16(ADDR_CNT_LO, 16'h1234);
		cpu.wr(ADDR_CNT_HI, 8'h77);
		@(negedge core_clk);
		chk(count_value, 16'h1234);
		cpu.rd(ADDR_CMPA_HI, b);
		chk(16'(b), 16'h00ab);
		cpu.rd(ADDR_CNT_HI, b);
		chk(16'(b), 16'h0077);
		@(posedge core_clk);
		capture_strobe <= 1'b1;
		@(posedge core_clk);
		capture_strobe <= 1'b0;
		cpu.rd16(ADDR_CAP_LO, v);
		chk(v, 16'h1234);
		// Capture writes are refused while the capture register does not set TOP.
		cpu.wr16(ADDR_CAP_LO, 16'h5555);
		cpu.rd16(ADDR_CAP_LO, v);
		chk(v, 16'h1234);
		// Normal mode wraps from MAX to BOTTOM and raises the overflow flag.
		cpu.wr16(ADDR_CNT_LO, 16'hfffd);
		cpu.wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
		for (k = 0; k < 20 && max_flag !== 1'b1; k++) @(negedge core_clk);
		chk(count_value, CNT_MAX);
		@(negedge core_clk);
		chk(count_value, CNT_BOTTOM);
		chk(16'(bottom_flag), 16'h0001);
		chk(16'(overflow_flag), 16'h0001);
		cpu.wr16(ADDR_CNT_LO, 16'h4000);
		@(negedge core_clk);
		chk(count_value, 16'h4000);
		@(negedge core_clk);
		chk(count_value, 16'h4001);
		chk(16'(timer_clock_enable), 16'h0001);
		cpu.wr(ADDR_FLAGS, 8'h01);
		@(negedge core_clk);
		chk(16'(overflow_flag), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			cpu.wr(ADDR_CTRL_B, {5'h00, CS_DIV8 + 3'(i)});
			tick_gap(k);
			tick_gap(k);
			tick_gap(k);
			chk(16'(k), 16'(div_tab[i]));
		end
		cpu.wr16(ADDR_CMPA_LO, 16'h0040);
		for (int i = 0; i < 10; i++) begin
			m = mode_tab[i];
			dual = (m < WGM_CTC_A) || (m == WGM_PC_A);
			cpu.wr(ADDR_CTRL_B, 8'h00);
			// Passing through mode zero clears a downward direction left by a dual-slope run.
			cpu.wr(ADDR_CTRL_A, 8'h00);
			cpu.wr(ADDR_CTRL_A, {6'h00, m[1:0]});
			cpu.wr16(ADDR_CNT_LO, top_tab[i] - 16'h0003);
			cpu.wr(ADDR_CTRL_B, {3'h0, m[3:2], CS_DIV1});
			@(negedge core_clk);
			chk(16'(waveform_mode_field), 16'(m));
			for (k = 0; k < 2100 && top_flag !== 1'b1; k++) @(negedge core_clk);
			chk(count_value, top_tab[i]);
			@(negedge core_clk);
			chk(count_value, dual ? top_tab[i] - 16'h0001 : CNT_BOTTOM);
			chk(16'(count_down), 16'(dual));
		end
		// External edges: code 7 counts rising, code 6 counts falling.
		cpu.wr(ADDR_CTRL_A, 8'h00);
		for (int i = 0; i < 2; i++) begin
			cpu.wr(ADDR_CTRL_B, {5'h00, (i == 0) ? CS_EXT_RISE : CS_EXT_FALL});
			cpu.wr16(ADDR_CNT_LO, 16'h0100);
			@(posedge core_clk);
			external_count_pin <= 1'b1;
			repeat (6) @(negedge core_clk);
			chk(count_value, 16'h0100 + 16'(1 - i));
			@(posedge core_clk);
			external_count_pin <= 1'b0;
			repeat (6) @(negedge core_clk);
			chk(count_value, 16'h0101);
		end
		// A reset in mid-run must bring count and holder back to zero.
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		chk(count_value, WORD_RESET);
		cpu.rd(ADDR_CNT_HI, b);
		chk(16'(b), 16'(BYTE_RESET));
		results();
	end
endmodule
